// [crx_match_unit.sv]
`timescale 1ns/1ns
`include "crx_regs.svh"

module crx_match_unit #(
  parameter int ID_W = `CRX_ID_W,
  parameter int STD_W = `CRX_STD_W
) (
  input wire logic [ID_W-1:0] frame_id,
  input wire logic frame_ide,
  input wire logic [ID_W-1:0] buf_id,
  input wire logic buf_ide,
  input wire logic buf_enable,
  input wire crx_pkg::crx_cmp_type mode,
  input wire logic [ID_W-1:0] mask0,
  input wire logic [ID_W-1:0] mask1,
  output logic hit,
  output logic via_mask
);

  // ----------------------------------------
  // care bits: 1 means the bit is compared
  // ----------------------------------------
  wire [ID_W-1:0] std_sel = {{STD_W{1'b1}}, {(ID_W-STD_W){1'b0}}};
  wire [ID_W-1:0] care_raw = (mode == crx_pkg::CRX_CMP_MASK0) ? mask0 :
                             (mode == crx_pkg::CRX_CMP_MASK1) ? mask1 : {ID_W{1'b1}}; // R6
  // frame format taken from this buffer alone
  wire [ID_W-1:0] care_eff = buf_ide ? care_raw : (care_raw & std_sel); // R13
  wire id_equal = ((buf_id ^ frame_id) & care_eff) == {ID_W{1'b0}};

  assign hit = buf_enable && (mode != crx_pkg::CRX_CMP_HOLDER) && (buf_ide == frame_ide) && id_equal; // R7 R13
  assign via_mask = (mode == crx_pkg::CRX_CMP_MASK0) || (mode == crx_pkg::CRX_CMP_MASK1);

endmodule // crx_match_unit

// [crx_mem_model.sv]
`timescale 1ns/1ns

module crx_mem_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rx_store_req,
  input wire logic [3:0] rx_store_index,
  output logic store_done,
  output logic [3:0] store_done_index
);
  // ----
  // copy delay alternates quick and slow
  // ----
  logic [2:0] cnt_r;
  logic slow_r;
  logic [3:0] idx_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 3'h0;
      slow_r <= 1'b0;
      idx_r <= 4'h0;
      store_done <= 1'b0;
      store_done_index <= 4'h0;
    end else begin
      store_done <= (cnt_r == 3'h1);
      store_done_index <= (cnt_r == 3'h1) ? idx_r : ~store_done_index;
      if (rx_store_req) begin
        idx_r <= rx_store_index;
        cnt_r <= slow_r ? 3'h5 : 3'h1;
        slow_r <= ~slow_r;
      end else if (cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end
endmodule // crx_mem_model

// [crx_pkg.sv]
package crx_pkg;

  // compare mode of one receive buffer
  typedef enum logic [1:0] {
    CRX_CMP_FULL,
    CRX_CMP_MASK0,
    CRX_CMP_MASK1,
    CRX_CMP_HOLDER
  } crx_cmp_type;

endpackage

// [crx_prio_select.sv]
`timescale 1ns/1ns
`include "crx_regs.svh"

module crx_prio_select #(
  parameter int N = `CRX_NBUF,
  parameter int IDX_W = `CRX_IDX_W
) (
  input wire logic [N-1:0] hit,
  input wire logic [N-1:0] via_mask,
  output logic found,
  output logic [IDX_W-1:0] index
);

  wire [N-1:0] plain_hit = hit & ~via_mask;
  wire [N-1:0] mask_hit = hit & via_mask;

  // ----------------------------------------
  // plain buffers first, then lowest number
  // ----------------------------------------
  always_comb begin
    found = 1'b0;
    index = {IDX_W{1'b0}};
    for (int i = N - 1; i >= 0; i--) begin
      if (mask_hit[i]) begin // R21
        found = 1'b1;
        index = IDX_W'(i);
      end
    end
    for (int i = N - 1; i >= 0; i--) begin
      if (plain_hit[i]) begin // R20 R21
        found = 1'b1;
        index = IDX_W'(i);
      end
    end
  end

endmodule // crx_prio_select

// [crx_regs.svh]
`ifndef CRX_REGS_SVH
`define CRX_REGS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define CRX_ADDR_W 16
`define CRX_ADDR_NEW_MSG 16'hffb2
`define CRX_ADDR_MASK_CTL 16'hffbb

// ----------------------------------------
// reset values
// ----------------------------------------
`define CRX_RST_NEW_MSG 8'h00
`define CRX_RST_MASK_CTL 8'h00

// ----------------------------------------
// mask control fields
// ----------------------------------------
`define CRX_MC_MASK_ZERO_ENABLE 0
`define CRX_MC_MASK_ONE_ENABLE 1
`define CRX_MC_GLOBAL 2
`define CRX_MC_ZERO 3
`define CRX_MC_REQUEUE 4
`define CRX_MC_SSHOT 5
`define CRX_MC_PRE_LO 6
`define CRX_MC_PRE_HI 7
`define CRX_MC_WMASK 8'hf7

// ----------------------------------------
// identifier layout and buffer counts
// ----------------------------------------
`define CRX_ID_W 29
`define CRX_STD_W 11
`define CRX_NBUF 16
`define CRX_NFLAG 8
`define CRX_IDX_W 4
`define CRX_BRP_W 6

`endif

// [crx_status_mask.sv]
`timescale 1ns/1ns
`include "crx_regs.svh"

// Contract
// R1: store done sets flag of buffers 0-7
// R2: flag mirrors new-data bit, CPU clear
// R3: flag register read-only, multiple bits allowed
// R4: flags zero at reset and init
// R5: flag 0/2 meaningless when mask holder
// R6: mask selects compared identifier bits
// R7: mask holder buffer never stores frames
// R8: mask enable 0: buffer 0 masks 1
// R9: mask enable 1: buffer 2 masks 3; code leaves buffer 3 at full compare when global is set
// R10: global: highest mask covers later buffers
// R11: global both masks: 4-15 via mask1
// R12: global mask1 only: 4-15 via mask1
// R13: frame format from buffer's own bit
// R14: single shot: no retry after error
// R15: single shot arbitration loss: requeue bit decides
// R16: upper prescaler bits extend time quantum
// R17: extension only with time measure mode
// R18: software writes mask control only in init
// R19: mask control resets zero, bit3 zero
// R20: plain buffers beat masked buffers
// R21: lowest numbered matching buffer wins
// R22: unmatched frame discarded, flags unchanged
module crx_status_mask #(
  parameter int NBUF = `CRX_NBUF,
  parameter int NFLAG = `CRX_NFLAG,
  parameter int ID_W = `CRX_ID_W,
  parameter int IDX_W = `CRX_IDX_W,
  parameter int BRP_W = `CRX_BRP_W
) (
  input wire logic core_clk,
  input wire logic rst,
  // cpu special function register port
  input wire logic [`CRX_ADDR_W-1:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // controller state
  input wire logic init_request,
  input wire logic init_confirmed,
  input wire logic time_measure_mode,
  input wire logic [BRP_W-1:0] prescaler_low_bits,
  // received frame from the protocol engine
  input wire logic frame_valid,
  input wire logic [ID_W-1:0] frame_id,
  input wire logic frame_ide,
  // receive buffer definitions
  input wire logic [NBUF*ID_W-1:0] buf_id_flat,
  input wire logic [NBUF-1:0] buf_ide,
  input wire logic [NBUF-1:0] buf_rx_enable,
  // storage handshake with the memory engine
  output logic rx_store_req,
  output logic [IDX_W-1:0] rx_store_index,
  input wire logic store_done,
  input wire logic [IDX_W-1:0] store_done_index,
  input wire logic [NFLAG-1:0] dn_clear,
  output logic [NFLAG-1:0] buffer_new_data_bit,
  // transmit outcome handling
  input wire logic tx_error,
  input wire logic tx_arb_lost,
  output logic tx_retry,
  output logic tx_drop,
  // configuration seen by the rest of the controller
  output logic single_shot_enable,
  output logic requeue_after_arbitration_loss,
  output logic [1:0] prescaler_extension,
  output logic [BRP_W+1:0] tq_prescale,
  output logic [NBUF-1:0] buf_is_mask_holder
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] rx_new_message_flags_r;
  logic [7:0] rx_new_message_flags_nxt;
  logic [7:0] acceptance_mask_control_r;
  logic [7:0] sfr_rdata_r;
  logic [7:0] sfr_rdata_nxt;
  logic rx_store_req_r;
  logic [IDX_W-1:0] rx_store_index_r;
  logic tx_retry_r;
  logic tx_drop_r;
  logic [1:0] prescaler_extension_r;
  logic [BRP_W+1:0] tq_prescale_r;
  logic [NBUF-1:0] buf_is_mask_holder_r;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire sel_new_msg = (sfr_addr == `CRX_ADDR_NEW_MSG);
  wire sel_mask_ctl = (sfr_addr == `CRX_ADDR_MASK_CTL);
  // writes outside confirmed init are dropped
  wire mask_ctl_we = sfr_wr && sel_mask_ctl && init_confirmed; // R18

  // ----------------------------------------
  // mask control fields
  // ----------------------------------------
  wire mask_zero_enable = acceptance_mask_control_r[`CRX_MC_MASK_ZERO_ENABLE];
  wire mask_one_enable = acceptance_mask_control_r[`CRX_MC_MASK_ONE_ENABLE];
  wire global_mask_enable = acceptance_mask_control_r[`CRX_MC_GLOBAL];
  wire prescaler_extension_low = acceptance_mask_control_r[`CRX_MC_PRE_LO];
  wire prescaler_extension_high = acceptance_mask_control_r[`CRX_MC_PRE_HI];

  // ----------------------------------------
  // per-buffer compare mode
  // ----------------------------------------
  function automatic crx_pkg::crx_cmp_type crx_mode_of(
    input int idx,
    input logic glb,
    input logic m1,
    input logic m0
  );
    crx_pkg::crx_cmp_type m;
    m = crx_pkg::CRX_CMP_FULL;
    case (idx)
      0: begin
        if (m0) begin // R8
          m = crx_pkg::CRX_CMP_HOLDER;
        end
      end
      1: begin
        if (m0) begin // R8 R11
          m = crx_pkg::CRX_CMP_MASK0;
        end
      end
      2: begin
        if (m1) begin // R9 R12
          m = crx_pkg::CRX_CMP_HOLDER;
        end else if (glb && m0) begin // R10
          m = crx_pkg::CRX_CMP_MASK0;
        end
      end
      3: begin
        if (m1 && !glb) begin // R9 R11 R12
          m = crx_pkg::CRX_CMP_MASK1;
        end
      end
      default: begin
        if (glb && m1) begin // R11 R12
          m = crx_pkg::CRX_CMP_MASK1;
        end else if (glb && m0) begin // R10
          m = crx_pkg::CRX_CMP_MASK0;
        end
      end
    endcase
    return m;
  endfunction

  // ----------------------------------------
  // acceptance compare per buffer
  // ----------------------------------------
  wire [ID_W-1:0] mask0_bits = buf_id_flat[0*ID_W +: ID_W];
  wire [ID_W-1:0] mask1_bits = buf_id_flat[2*ID_W +: ID_W];
  wire [NBUF-1:0] buf_hit;
  wire [NBUF-1:0] buf_via_mask;
  wire [NBUF-1:0] holder_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < NBUF; gi++) begin : g_buf
      crx_pkg::crx_cmp_type mode;
      assign mode = crx_mode_of(gi, global_mask_enable, mask_one_enable, mask_zero_enable);
      assign holder_nxt[gi] = (mode == crx_pkg::CRX_CMP_HOLDER); // R7
      crx_match_unit #(
        .ID_W(ID_W),
        .STD_W(`CRX_STD_W)
      ) u_match (
        .frame_id(frame_id),
        .frame_ide(frame_ide),
        .buf_id(buf_id_flat[gi*ID_W +: ID_W]),
        .buf_ide(buf_ide[gi]),
        .buf_enable(buf_rx_enable[gi]),
        .mode(mode),
        .mask0(mask0_bits),
        .mask1(mask1_bits),
        .hit(buf_hit[gi]),
        .via_mask(buf_via_mask[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // storage priority
  // ----------------------------------------
  wire any_found;
  wire [IDX_W-1:0] best_index;

  crx_prio_select #(
    .N(NBUF),
    .IDX_W(IDX_W)
  ) u_prio (
    .hit(buf_hit),
    .via_mask(buf_via_mask),
    .found(any_found),
    .index(best_index)
  );

  // no request when nothing matched or in init
  wire store_req_nxt = frame_valid && any_found && !init_request; // R22

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_store_req_r <= 1'b0;
      rx_store_index_r <= {IDX_W{1'b0}};
    end else begin
      rx_store_req_r <= store_req_nxt;
      if (store_req_nxt) begin
        rx_store_index_r <= best_index; // R20 R21
      end
    end
  end

  // ----------------------------------------
  // new-message flags
  // ----------------------------------------
  wire [NFLAG-1:0] flag_set;
  wire [NFLAG-1:0] flag_clr;

  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      // set only after copy from shadow buffer ends
      assign flag_set[gi] = store_done && (store_done_index == IDX_W'(gi)); // R1
      assign flag_clr[gi] = dn_clear[gi] || init_request; // R2 R4
      // set beats any clear in the same cycle
      assign rx_new_message_flags_nxt[gi] = flag_set[gi] ||
                                            (rx_new_message_flags_r[gi] && !flag_clr[gi]); // R1 R2 R3
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_new_message_flags_r <= `CRX_RST_NEW_MSG; // R4
    end else begin
      rx_new_message_flags_r <= rx_new_message_flags_nxt;
    end
  end

  // flags of holder buffers kept as is, software ignores them
  assign buffer_new_data_bit = rx_new_message_flags_r; // R2 R5

  // ----------------------------------------
  // mask control register
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acceptance_mask_control_r <= `CRX_RST_MASK_CTL; // R19
    end else if (mask_ctl_we) begin
      acceptance_mask_control_r <= sfr_wdata & `CRX_MC_WMASK; // R18 R19
    end
  end

  // ----------------------------------------
  // register read path
  // ----------------------------------------
  assign sfr_rdata_nxt = sel_new_msg ? rx_new_message_flags_r : // R3
                         sel_mask_ctl ? (acceptance_mask_control_r & `CRX_MC_WMASK) : // R19
                         8'h00;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_r <= sfr_rdata_nxt;
    end
  end

  assign sfr_rdata = sfr_rdata_r;

  // ----------------------------------------
  // single-shot transmit decisions
  // ----------------------------------------
  assign single_shot_enable = acceptance_mask_control_r[`CRX_MC_SSHOT];
  assign requeue_after_arbitration_loss = acceptance_mask_control_r[`CRX_MC_REQUEUE];

  // single shot never retries an errored frame
  wire err_retry = tx_error && !single_shot_enable; // R14
  wire err_drop = tx_error && single_shot_enable; // R14
  wire arb_retry = tx_arb_lost && (!single_shot_enable || requeue_after_arbitration_loss); // R15
  wire arb_drop = tx_arb_lost && single_shot_enable && !requeue_after_arbitration_loss; // R15
  wire retry_nxt = err_retry || arb_retry;
  wire drop_nxt = err_drop || arb_drop;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_retry_r <= 1'b0;
      tx_drop_r <= 1'b0;
    end else begin
      tx_retry_r <= retry_nxt;
      tx_drop_r <= drop_nxt;
    end
  end

  assign tx_retry = tx_retry_r;
  assign tx_drop = tx_drop_r;

  // ----------------------------------------
  // prescaler extension
  // ----------------------------------------
  // upper bits count only in time measure mode
  wire [1:0] prescaler_extension_nxt = time_measure_mode ?
                                       {prescaler_extension_high, prescaler_extension_low} : 2'b00; // R17
  // upper bits add blocks of 64 clocks to the quantum
  wire [BRP_W+1:0] tq_prescale_nxt = {prescaler_extension_nxt, prescaler_low_bits}; // R16

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prescaler_extension_r <= 2'b00;
      tq_prescale_r <= {(BRP_W+2){1'b0}};
    end else begin
      prescaler_extension_r <= prescaler_extension_nxt;
      tq_prescale_r <= tq_prescale_nxt;
    end
  end

  assign prescaler_extension = prescaler_extension_r;
  assign tq_prescale = tq_prescale_r;

  // ----------------------------------------
  // mask holder map
  // ----------------------------------------
  // follows the mask control register one cycle later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      buf_is_mask_holder_r <= {NBUF{1'b0}};
    end else begin
      buf_is_mask_holder_r <= holder_nxt; // R7
    end
  end

  assign buf_is_mask_holder = buf_is_mask_holder_r;

  // ----------------------------------------
  // storage outputs
  // ----------------------------------------
  assign rx_store_req = rx_store_req_r;
  assign rx_store_index = rx_store_index_r;

endmodule // crx_status_mask

// [crx_status_mask_properties.sv]
`timescale 1ns/1ns
`include "crx_regs.svh"

module crx_status_mask_chk #(
  parameter int NBUF = `CRX_NBUF,
  parameter int NFLAG = `CRX_NFLAG,
  parameter int IDX_W = `CRX_IDX_W,
  parameter int BRP_W = `CRX_BRP_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`CRX_ADDR_W-1:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic init_request,
  input wire logic time_measure_mode,
  input wire logic [BRP_W-1:0] prescaler_low_bits,
  input wire logic rx_store_req,
  input wire logic [IDX_W-1:0] rx_store_index,
  input wire logic store_done,
  input wire logic [IDX_W-1:0] store_done_index,
  input wire logic [NFLAG-1:0] dn_clear,
  input wire logic [NFLAG-1:0] buffer_new_data_bit,
  input wire logic tx_error,
  input wire logic tx_arb_lost,
  input wire logic tx_retry,
  input wire logic tx_drop,
  input wire logic single_shot_enable,
  input wire logic requeue_after_arbitration_loss,
  input wire logic [1:0] prescaler_extension,
  input wire logic [BRP_W+1:0] tq_prescale,
  input wire logic [NBUF-1:0] buf_is_mask_holder
);
  // ----
  // flag set vector, set wins over clear
  // ----
  logic [NFLAG-1:0] set_v;
  assign set_v = store_done ? NFLAG'(1) << store_done_index : '0;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_err_single;
    tx_error && !tx_arb_lost && single_shot_enable;
  endsequence
  sequence s_arb_single;
    tx_arb_lost && !tx_error && single_shot_enable;
  endsequence

  chk_flag_set: assert property (
    store_done && store_done_index < NFLAG |=> buffer_new_data_bit[$past(store_done_index)])
    else $error("flag not set after store");
  chk_flag_clear: assert property (
    |(dn_clear & ~set_v) |=> (buffer_new_data_bit & $past(dn_clear) & ~$past(set_v)) == '0)
    else $error("flag not cleared");
  chk_init_clear: assert property (
    init_request |=> (buffer_new_data_bit & ~$past(set_v)) == '0)
    else $error("flags not cleared by init");
  chk_bit_three: assert property (
    sfr_rd && sfr_addr == `CRX_ADDR_MASK_CTL |=> !sfr_rdata[3])
    else $error("mask control bit 3 set");
  chk_prescale_ext: assert property (
    1'b1 |=> tq_prescale == {prescaler_extension, $past(prescaler_low_bits)} &&
             ($past(time_measure_mode) || prescaler_extension == 2'b00))
    else $error("prescaler code wrong");
  chk_error_drop: assert property (
    s_err_single |=> tx_drop && !tx_retry)
    else $error("single shot error retried");
  chk_arb_requeue: assert property (
    s_arb_single |=> tx_retry == $past(requeue_after_arbitration_loss) && tx_drop == !tx_retry)
    else $error("arbitration loss handling wrong");
  chk_holder_store: assert property (
    rx_store_req |-> !buf_is_mask_holder[rx_store_index])
    else $error("store into mask holder");
endmodule // crx_status_mask_chk

bind crx_status_mask crx_status_mask_chk #(.NBUF(NBUF), .NFLAG(NFLAG), .IDX_W(IDX_W), .BRP_W(BRP_W)) u_chk (
  .core_clk, .rst, .sfr_addr, .sfr_rd, .sfr_rdata, .init_request, .time_measure_mode, .prescaler_low_bits,
  .rx_store_req, .rx_store_index, .store_done, .store_done_index, .dn_clear, .buffer_new_data_bit, .tx_error,
  .tx_arb_lost, .tx_retry, .tx_drop, .single_shot_enable, .requeue_after_arbitration_loss,
  .prescaler_extension, .tq_prescale, .buf_is_mask_holder
);

// [tb_top.sv]
`timescale 1ns/1ns
`include "crx_regs.svh"

module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] sfr_addr = 16'h0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h0;
  logic init_request = 1'b0;
  logic init_confirmed = 1'b0;
  logic time_measure_mode = 1'b0;
  logic [5:0] prescaler_low_bits = 6'h2a;
  logic frame_valid = 1'b0;
  logic [28:0] frame_id = 29'h0123_4567;
  logic frame_ide = 1'b1;
  logic [`CRX_NBUF*`CRX_ID_W-1:0] buf_id_flat;
  logic [15:0] buf_ide = 16'hffff;
  logic [15:0] buf_rx_enable = 16'h0;
  logic [7:0] dn_clear = 8'h0;
  logic tx_error = 1'b0;
  logic tx_arb_lost = 1'b0;
  logic [7:0] sfr_rdata, buffer_new_data_bit, tq_prescale;
  logic [3:0] rx_store_index, store_done_index;
  logic [15:0] buf_is_mask_holder;
  logic [1:0] prescaler_extension;
  logic rx_store_req, store_done, tx_retry, tx_drop, single_shot_enable, requeue_after_arbitration_loss;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  always #20 core_clk = ~core_clk;

  crx_status_mask u_dut (
    .core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .init_request, .init_confirmed,
    .time_measure_mode, .prescaler_low_bits, .frame_valid, .frame_id, .frame_ide, .buf_id_flat, .buf_ide,
    .buf_rx_enable, .rx_store_req, .rx_store_index, .store_done, .store_done_index, .dn_clear,
    .buffer_new_data_bit, .tx_error, .tx_arb_lost, .tx_retry, .tx_drop, .single_shot_enable,
    .requeue_after_arbitration_loss, .prescaler_extension, .tq_prescale, .buf_is_mask_holder
  );
  crx_mem_model u_mem (.core_clk, .rst, .rx_store_req, .rx_store_index, .store_done, .store_done_index);

  // ----
  // checking and bus tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] want);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 chk(sfr_rdata, want);
  endtask

  task automatic set_mc(input logic [7:0] mc);
    @(posedge core_clk);
    init_request <= 1'b1;
    init_confirmed <= 1'b1;
    wr(`CRX_ADDR_MASK_CTL, mc);
    @(posedge core_clk);
    init_request <= 1'b0;
    init_confirmed <= 1'b0;
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    rd(`CRX_ADDR_NEW_MSG, 8'h00);
    rd(`CRX_ADDR_MASK_CTL, 8'h00);
    rd(16'hffb4, 8'h00);
    wr(`CRX_ADDR_MASK_CTL, 8'hff);
    rd(`CRX_ADDR_MASK_CTL, 8'h00);
    set_mc(8'hff);
    rd(`CRX_ADDR_MASK_CTL, 8'hf7);
    chk(prescaler_extension, 2'b00);
    wr(`CRX_ADDR_NEW_MSG, 8'hff);
    rd(`CRX_ADDR_NEW_MSG, 8'h00);
    for (int c = 0; c < 4; c++) begin
      set_mc({c[1:0], 6'h00});
      time_measure_mode <= 1'b1;
      @(posedge core_clk);
      #1 chk(tq_prescale, {c[1:0], 6'h2a});
    end
    @(posedge core_clk);
    time_measure_mode <= 1'b0;
  endtask

  task automatic t_tx;
    logic [1:0] want;
    for (int i = 0; i < 8; i++) begin
      set_mc({2'b00, i[2:1], 4'h0});
      #1 chk({single_shot_enable, requeue_after_arbitration_loss}, i[2:1]);
      want = (!i[2] || (i[0] && i[1])) ? 2'b10 : 2'b01;
      @(posedge core_clk);
      tx_error <= !i[0];
      tx_arb_lost <= i[0];
      @(posedge core_clk);
      tx_error <= 1'b0;
      tx_arb_lost <= 1'b0;
      #1 chk({tx_retry, tx_drop}, want);
    end
  endtask

  task automatic t_frame(input logic [15:0] en, input logic ide, input logic hit, input logic [3:0] idx,
                         input logic [7:0] fl);
    @(posedge core_clk);
    buf_rx_enable <= en;
    frame_ide <= ide;
    frame_valid <= 1'b1;
    @(posedge core_clk);
    frame_valid <= 1'b0;
    #1 chk(rx_store_req, hit);
    if (hit) chk(rx_store_index, idx);
    repeat (8) @(posedge core_clk);
    #1 chk(buffer_new_data_bit, fl);
  endtask

  task automatic t_prio;
    set_mc(8'h00);
    t_frame(16'hfdff, 1'b1, 1'b0, 4'h0, 8'h00);
    set_mc(8'h01);
    t_frame(16'hfdff, 1'b1, 1'b1, 4'h1, 8'h02);
    t_frame(16'hffff, 1'b1, 1'b1, 4'h9, 8'h02);
    set_mc(8'h02);
    t_frame(16'hfdff, 1'b1, 1'b1, 4'h3, 8'h08);
    set_mc(8'h03);
    #1 chk(buf_is_mask_holder, 16'h0005);
    t_frame(16'hfdff, 1'b1, 1'b1, 4'h1, 8'h02);
    t_frame(16'hfdfd, 1'b1, 1'b1, 4'h3, 8'h0a);
    t_frame(16'hfdff, 1'b0, 1'b0, 4'h0, 8'h0a);
    @(posedge core_clk);
    dn_clear <= 8'h02;
    @(posedge core_clk);
    dn_clear <= 8'h00;
    #1 chk(buffer_new_data_bit, 8'h08);
    rd(`CRX_ADDR_NEW_MSG, 8'h08);
    set_mc(8'h05);
    #1 chk(buf_is_mask_holder, 16'h0001);
    t_frame(16'hfdfd, 1'b1, 1'b1, 4'h2, 8'h04);
    set_mc(8'h06);
    #1 chk(buf_is_mask_holder, 16'h0004);
    t_frame(16'hfdff, 1'b1, 1'b1, 4'h4, 8'h10);
    set_mc(8'h07);
    t_frame(16'hfdfd, 1'b1, 1'b1, 4'h4, 8'h10);
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test;
    end
  end

  initial begin
    for (int n = 0; n < `CRX_NBUF; n++) begin
      buf_id_flat[n*`CRX_ID_W +: `CRX_ID_W] <= (n == 0) ? 29'h1fff_fff0 : (n == 9 ? frame_id : frame_id ^ 29'h1);
    end
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_regs;
    t_tx;
    t_prio;
    end_of_test;
  end
endmodule // tb_top
